// ===== design/i2c_ack_pkg.sv
// shared constants and types for the i2c slave acknowledge-phase block
package i2c_ack_pkg;
   localparam int          ADDR_W        = 10;      // own address width, 10-bit mode
   localparam int          BYTE_W        = 8;       // bits per byte on the bus
   localparam int          FIFO_DEPTH    = 16;      // receive buffer depth in words
   localparam int          FIFO_WIDTH    = 9;       // byte plus address marker
   localparam logic [3:0]  BITS_PER_BYTE = 4'h8;    // data bits before the ack clock
   localparam logic [4:0]  ADDR10_PREFIX = 5'h1e;   // upper address byte marker 11110
   localparam int          ACK_PHASE_POS = 13;      // status bit position of ack phase flag
   localparam int          RX_FULL_POS   = 1;       // status bit position of buffer full

   // byte position within a transaction
   typedef enum logic [2:0] {
      PH_IDLE,
      PH_ADDR_FIRST,
      PH_ADDR_LOW,
      PH_DATA,
      PH_IGNORE
   } phase_t;
endpackage

// ===== design/i2c_slave_ack_timing.sv
// i2c slave receiver with acknowledge-phase status, address hold and receive fifo

////////////////////////////////////////////////////////////////////////////////
// receive fifo, single clock; depth must be a power of two
module rx_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,       // system clock
   input  wire logic             rst_i,       // synchronous reset, active high
   input  wire logic             ce_i,        // clock enable, freezes state when low
   input  wire logic             in_valid_i,  // write request
   output logic                  in_ready_o,  // room for one more word
   input  wire logic [WIDTH-1:0] in_data_i,   // word to store
   output logic                  out_valid_o, // a word is waiting
   input  wire logic             out_ready_i, // consumer takes the word
   output logic [WIDTH-1:0]      out_data_o   // oldest word
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } fifo_st_t;
   fifo_st_t f;
   fifo_st_t next_f;
   logic     do_wr;
   logic     do_rd;
   // handshake flags straight from the count
   assign in_ready_o  = (f.cnt != FULL_CNT);
   assign out_valid_o = (f.cnt != '0);
   assign out_data_o  = f.mem[f.rp];
   assign do_wr       = in_valid_i & in_ready_o;
   assign do_rd       = out_ready_i & out_valid_o;
   // pointer and count update; pointers wrap naturally at power-of-two depth
   always_comb begin
      next_f = f;
      if (ce_i) begin
         if (do_wr) begin
            next_f.mem[f.wp] = in_data_i;
            next_f.wp        = f.wp + 1'b1;
         end
         if (do_rd) begin
            next_f.rp = f.rp + 1'b1;
         end
         // a write and a read in one cycle leave the count alone
         next_f.cnt = f.cnt + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
      if (rst_i) begin
         next_f = '0;
      end
   end
   always_ff @(posedge clk_i) begin
      f <= next_f;
   end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: bus engine on the link clock, status and buffer on the system clock
module i2c_slave_ack_timing
   import i2c_ack_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input  wire logic              clk_sys_i,             // system clock, 100 MHz
   input  wire logic              sys_rst_i,             // synchronous reset, active high
   input  wire logic              ce_i,                  // clock enable, low freezes state
   input  wire logic              link_clk_i,            // bus sampling clock
   input  wire logic              scl_i,                 // bus clock level seen on the pin
   output logic                   scl_o,                 // bus clock drive value, always low
   output logic                   scl_oe_o,              // high while stretching the clock
   input  wire logic              sda_i,                 // bus data level seen on the pin
   output logic                   sda_o,                 // bus data drive value, always low
   output logic                   sda_oe_o,              // high while driving acknowledge
   input  wire logic [ADDR_W-1:0] own_addr_i,            // own slave address
   input  wire logic              ten_bit_mode_i,        // 10-bit addressing enable
   input  wire logic              address_hold_option_i, // stretch after eighth fall
   input  wire logic              hold_release_i,        // pulse: release held clock
   output logic [BYTE_W-1:0]      rx_data_o,             // oldest received byte
   output logic                   rx_is_addr_o,          // oldest byte was an address
   output logic                   receive_buffer_full_o, // a received byte is waiting
   input  wire logic              rx_ready_i,            // pulse: software takes the byte
   output logic                   ack_phase_status_o,    // acknowledge phase flag
   output logic                   clock_held_o           // bus clock is being stretched
);
   // link domain state
   typedef struct packed {
      logic [1:0]             ce_s;
      logic [1:0]             scl_s;
      logic [1:0]             sda_s;
      logic                   scl_q;
      logic                   sda_q;
      logic [1:0]             rel_s;
      logic                   rel_q;
      logic [1:0]             space_s;
      logic [1:0]             ten_s;
      logic [1:0]             hold_opt_s;
      logic [1:0][ADDR_W-1:0] own_s;
      phase_t                 phase;
      logic [3:0]             bit_cnt;
      logic [BYTE_W-1:0]      shreg;
      logic                   ack_win;
      logic                   ack_drive;
      logic                   hold;
      logic                   pend;
      logic                   flag;
      logic                   push_tgl;
      logic                   push_addr;
      logic [BYTE_W-1:0]      push_byte;
      logic                   clk_low;
   } link_st_t;
   // system domain state
   typedef struct packed {
      logic [1:0]            flag_s;
      logic [1:0]            held_s;
      logic [1:0]            tgl_s;
      logic                  tgl_q;
      logic                  in_valid;
      logic [FIFO_WIDTH-1:0] in_data;
      logic                  rel_tgl;
   } sys_st_t;
   link_st_t              l;
   link_st_t              next_l;
   sys_st_t               s;
   sys_st_t               next_s;
   logic [1:0]            rst_lk;
   logic                  fifo_in_ready;
   logic [FIFO_WIDTH-1:0] fifo_out;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_det;
   logic                  stop_det;
   logic                  rel_edge;
   logic                  byte_ok;
   phase_t                after_phase;
   // reset brought into the link domain; the link clock never stops here
   always_ff @(posedge link_clk_i) begin
      rst_lk <= {rst_lk[0], sys_rst_i};
   end
   // bus events from the second synchroniser stage and its delayed copy
   assign scl_rise  = l.scl_s[1] & ~l.scl_q;
   assign scl_fall  = ~l.scl_s[1] & l.scl_q;
   assign start_det = l.scl_s[1] & l.scl_q & l.sda_q & ~l.sda_s[1];
   assign stop_det  = l.scl_s[1] & l.scl_q & ~l.sda_q & l.sda_s[1];
   assign rel_edge  = l.rel_s[1] ^ l.rel_q;
   // address compare for the byte just shifted in
   always_comb begin
      byte_ok     = 1'b0;
      after_phase = PH_IGNORE;
      case (l.phase)
         PH_ADDR_FIRST: begin
            if (l.ten_s[1]) begin
               byte_ok = (l.shreg[7:3] == ADDR10_PREFIX) &&
                         (l.shreg[2:1] == l.own_s[1][9:8]);
               after_phase = byte_ok ? PH_ADDR_LOW : PH_IGNORE;
            end else begin
               byte_ok     = (l.shreg[7:1] == l.own_s[1][6:0]);
               after_phase = byte_ok ? PH_DATA : PH_IGNORE;
            end
         end
         PH_ADDR_LOW: begin
            byte_ok     = (l.shreg == l.own_s[1][7:0]);
            after_phase = byte_ok ? PH_DATA : PH_IGNORE;
         end
         PH_DATA: begin
            byte_ok     = 1'b1;
            after_phase = PH_DATA;
         end
         default: after_phase = PH_IGNORE;
      endcase
   end
   // bus engine; everything but the enable synchroniser freezes with the enable
   always_comb begin
      next_l      = l;
      next_l.ce_s = {l.ce_s[0], ce_i};
      if (l.ce_s[1]) begin
         next_l.scl_s      = {l.scl_s[0], scl_i};
         next_l.sda_s      = {l.sda_s[0], sda_i};
         next_l.scl_q      = l.scl_s[1];
         next_l.sda_q      = l.sda_s[1];
         next_l.rel_s      = {l.rel_s[0], s.rel_tgl};
         next_l.rel_q      = l.rel_s[1];
         next_l.space_s    = {l.space_s[0], fifo_in_ready};
         next_l.ten_s      = {l.ten_s[0], ten_bit_mode_i};
         next_l.hold_opt_s = {l.hold_opt_s[0], address_hold_option_i};
         next_l.own_s      = {l.own_s[0], own_addr_i};
         if (stop_det || start_det) begin
            // stop ends every transaction, also an ignored one; start opens a new one
            next_l.phase     = start_det ? PH_ADDR_FIRST : PH_IDLE;
            next_l.bit_cnt   = '0;
            next_l.ack_win   = 1'b0;
            next_l.ack_drive = 1'b0;
            next_l.hold      = 1'b0;
            next_l.pend      = 1'b0;
            next_l.flag      = 1'b0;
         end else if (l.phase != PH_IDLE) begin
            // a full buffer keeps the clock low until a word drains
            if (l.pend && l.space_s[1]) begin
               next_l.pend     = 1'b0;
               next_l.push_tgl = ~l.push_tgl;
            end
            if (l.hold && rel_edge) begin
               next_l.hold = 1'b0;
            end
            if (scl_rise) begin
               if (l.ack_win) begin
                  next_l.flag = 1'b0;
               end else if (l.bit_cnt != BITS_PER_BYTE) begin
                  next_l.shreg   = {l.shreg[6:0], l.sda_s[1]};
                  next_l.bit_cnt = l.bit_cnt + 4'h1;
               end
            end else if (scl_fall) begin
               if (l.ack_win) begin
                  next_l.ack_win   = 1'b0;
                  next_l.ack_drive = 1'b0;
                  next_l.bit_cnt   = '0;
               end else if (l.bit_cnt == BITS_PER_BYTE) begin
                  next_l.ack_win = 1'b1;
                  next_l.phase   = after_phase;
                  if (byte_ok) begin
                     next_l.flag      = 1'b1;
                     next_l.ack_drive = 1'b1;
                     next_l.hold      = l.hold_opt_s[1];
                     next_l.pend      = 1'b1;
                     next_l.push_byte = l.shreg;
                     next_l.push_addr = (l.phase != PH_DATA);
                  end
               end
            end
         end
         // stretch only for the hold option or while the buffer has no room
         next_l.clk_low = next_l.hold | (next_l.pend & ~l.space_s[1]);
      end
      if (rst_lk[1]) begin
         next_l = '0;
      end
   end
   always_ff @(posedge link_clk_i) begin
      l <= next_l;
   end
   // pins: open-drain, only ever pulled low
   assign scl_o    = 1'b0;
   assign sda_o    = 1'b0;
   assign scl_oe_o = l.clk_low;
   assign sda_oe_o = l.ack_drive;

   ////////////////////////////////////////////////////////////////////////////
   // system side: flag sync, byte handover by toggle, release request
   always_comb begin
      next_s = s;
      if (ce_i) begin
         next_s.flag_s   = {s.flag_s[0], l.flag};
         next_s.held_s   = {s.held_s[0], l.clk_low};
         next_s.tgl_s    = {s.tgl_s[0], l.push_tgl};
         next_s.tgl_q    = s.tgl_s[1];
         next_s.in_valid = s.tgl_s[1] ^ s.tgl_q;
         // push data stays still between toggles, so sampling it here is safe
         if (s.tgl_s[1] ^ s.tgl_q) begin
            next_s.in_data = {l.push_addr, l.push_byte};
         end
         if (hold_release_i) begin
            next_s.rel_tgl = ~s.rel_tgl;
         end
      end
      if (sys_rst_i) begin
         next_s = '0;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      s <= next_s;
   end
   rx_fifo #(.WIDTH (FIFO_WIDTH), .DEPTH (DEPTH)) u_fifo (
      .clk_i       (clk_sys_i),
      .rst_i       (sys_rst_i),
      .ce_i        (ce_i),
      .in_valid_i  (s.in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (s.in_data),
      .out_valid_o (receive_buffer_full_o),
      .out_ready_i (rx_ready_i),
      .out_data_o  (fifo_out)
   );

   assign rx_data_o          = fifo_out[BYTE_W-1:0];
   assign rx_is_addr_o       = fifo_out[BYTE_W];
   assign ack_phase_status_o = s.flag_s[1];
   assign clock_held_o       = s.held_s[1];
endmodule

// ===== dv/i2c_master_model.sv
// behavioural i2c bus master, open-drain on clock and data
module i2c_master_model (
   input  wire logic lclk_i,    // link clock paces the bus
   input  wire logic scl_i,     // resolved clock wire
   input  wire logic sda_i,     // resolved data wire
   output logic      scl_low_o, // pulls clock low
   output logic      sda_low_o, // pulls data low
   output logic      stuck_o    // clock never came back high
);
   timeunit 1ns;
   timeprecision 1ps;
   // bus idles released, pull-ups give high
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
      stuck_o   = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge lclk_i);
   endtask
   // a slave may stretch, so wait on the wire rather than our own release
   task automatic rise;
      int n;
      scl_low_o <= 1'b0;
      tick(1);
      for (n = 0; n < 1000 && scl_i !== 1'b1; n++) tick(1);
      if (scl_i !== 1'b1) stuck_o <= 1'b1;
   endtask
   task automatic bit_cycle(input logic v, output logic s);
      sda_low_o <= !v;
      tick(3);
      rise();
      tick(2);
      s = sda_i;
      tick(3);
      scl_low_o <= 1'b1;
      tick(3);
   endtask
   task automatic start;
      sda_low_o <= 1'b1;
      tick(4);
      scl_low_o <= 1'b1;
      tick(3);
   endtask
   task automatic stop;
      sda_low_o <= 1'b1;
      tick(3);
      rise();
      tick(4);
      sda_low_o <= 1'b0;
      tick(8);
   endtask
   // msb first, ninth clock with data released for the acknowledge
   task automatic wr_byte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_cycle(b[i], s);
      bit_cycle(1'b1, s);
      ack = !s;
   endtask
endmodule

// ===== dv/i2c_slave_ack_timing_sva.sv
// assertion checker for the i2c slave acknowledge-phase block
module i2c_ack_checker
   import i2c_ack_pkg::*;
#(
   parameter int DEPTH = FIFO_DEPTH
) (
   input wire logic clk_sys_i,             // system clock
   input wire logic sys_rst_i,             // reset, high
   input wire logic link_clk_i,            // link clock
   input wire logic scl_i,                 // bus clock wire
   input wire logic scl_o,                 // clock drive value
   input wire logic scl_oe_o,              // stretch enable
   input wire logic sda_o,                 // data drive value
   input wire logic sda_oe_o,              // ack enable
   input wire logic address_hold_option_i, // hold option
   input wire logic hold_release_i,        // release pulse
   input wire logic receive_buffer_full_o, // byte waiting
   input wire logic rx_ready_i,            // software pop
   input wire logic ack_phase_status_o,    // ack flag
   input wire logic clock_held_o           // stretch active
);
   ////////////////////////////////////////////////////////////////////////////////
   // flag run length while the clock is free; a stretch may hold it longer
   logic [7:0] flag_len;
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !ack_phase_status_o || clock_held_o) flag_len <= 8'h00;
      else if (flag_len != 8'hff) flag_len <= flag_len + 8'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////
   a_drive_low_only: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      !scl_o && !sda_o) else $error("pin drive value not low");
   a_reset_clean: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      $fell(sys_rst_i) |-> !receive_buffer_full_o && !ack_phase_status_o && !clock_held_o)
      else $error("status not clear after reset");
   a_stretch_in_ack: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      scl_oe_o |-> sda_oe_o) else $error("clock stretched outside acknowledge");
   a_ack_starts_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      $rose(sda_oe_o) |-> !scl_i) else $error("acknowledge began with clock high");
   a_ack_ends_low: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
      $fell(sda_oe_o) |-> !scl_i) else $error("acknowledge ended with clock high");
   a_flag_short: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      flag_len < 8'd100) else $error("ack flag too long without stretch");
   a_hold_keeps_flag: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      address_hold_option_i && clock_held_o && $past(clock_held_o, 3) |-> ack_phase_status_o)
      else $error("ack flag dropped while held");
   a_release_bound: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      clock_held_o && hold_release_i |-> ##[1:100] !clock_held_o)
      else $error("held clock not released");
   a_full_kept: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
      receive_buffer_full_o && !rx_ready_i |=> receive_buffer_full_o)
      else $error("byte lost without pop");

   // main scenarios reached
   c_hold: cover property (@(posedge clk_sys_i) $rose(clock_held_o) && address_hold_option_i);
   c_stall: cover property (@(posedge clk_sys_i) clock_held_o && !address_hold_option_i);
   c_pop: cover property (@(posedge clk_sys_i) receive_buffer_full_o && rx_ready_i);
endmodule

bind i2c_slave_ack_timing i2c_ack_checker #(.DEPTH(DEPTH)) u_chk (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i), .scl_i(scl_i),
   .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
   .address_hold_option_i(address_hold_option_i), .hold_release_i(hold_release_i),
   .receive_buffer_full_o(receive_buffer_full_o), .rx_ready_i(rx_ready_i),
   .ack_phase_status_o(ack_phase_status_o), .clock_held_o(clock_held_o));

// ===== dv/i2c_slave_ack_timing_tb.sv
// self-checking bench for the i2c slave acknowledge-phase block
module i2c_slave_ack_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import i2c_ack_pkg::*;
   logic              clk = 1'b0, lclk = 1'b0, rst = 1'b1, ten = 1'b0, hold = 1'b0;
   logic              rel = 1'b0, rdy = 1'b0, fq = 1'b0, hq = 1'b0;
   logic [ADDR_W-1:0] own = 10'h05a;
   logic              scl_oe, sda_oe, scl_o, sda_o, full, is_addr, flag, held;
   logic              m_scl, m_sda, stuck;
   logic [BYTE_W-1:0] rxd;
   int                miscompares = 0, comparisons = 0, rises = 0, holds = 0;
   wire               scl_w = !m_scl && !(scl_oe && !scl_o);
   wire               sda_w = !m_sda && !(sda_oe && !sda_o);

   always #5 clk = ~clk;
   // link clock offset so its edges never coincide with the system clock's
   initial begin
      #3;
      forever #40 lclk = ~lclk;
   end
   // count flag pulses and stretches as they start
   always @(posedge clk) begin
      if (flag === 1'b1 && fq !== 1'b1) rises++;
      if (held === 1'b1 && hq !== 1'b1) holds++;
      fq <= flag;
      hq <= held;
   end
   always @(posedge stuck) begin
      miscompares++;
      conclude();
   end

   i2c_slave_ack_timing #(.DEPTH(FIFO_DEPTH)) dut (
      .clk_sys_i(clk), .sys_rst_i(rst), .ce_i(1'b1), .link_clk_i(lclk), .scl_i(scl_w),
      .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .own_addr_i(own), .ten_bit_mode_i(ten), .address_hold_option_i(hold),
      .hold_release_i(rel), .rx_data_o(rxd), .rx_is_addr_o(is_addr),
      .receive_buffer_full_o(full), .rx_ready_i(rdy), .ack_phase_status_o(flag),
      .clock_held_o(held));
   i2c_master_model m (.lclk_i(lclk), .scl_i(scl_w), .sda_i(sda_w), .scl_low_o(m_scl),
      .sda_low_o(m_sda), .stuck_o(stuck));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk1(input string what, input logic exp, input logic got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %b, seen %b", what, exp, got);
      end
   endtask
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic chkn(input string what, input int exp, input int got);
      comparisons++;
      if (got != exp) begin
         miscompares++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask
   // bounded wait on a settled design output
   task automatic wait_hi(ref logic s);
      int n;
      for (n = 0; n < 20000 && s !== 1'b1; n++) @(posedge clk) #1;
      if (s !== 1'b1) begin
         miscompares++;
         conclude();
      end
   endtask
   task automatic pop(input logic a, input logic [7:0] d);
      @(posedge clk) #1;
      wait_hi(full);
      chk1("address marker", a, is_addr);
      chk8("received byte", d, rxd);
      @(posedge clk) rdy <= 1'b1;
      @(posedge clk) rdy <= 1'b0;
   endtask
   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic ack;
      m.wr_byte(b, ack);
      chk1("acknowledge", exp_ack, ack);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_plain;
      int r0 = rises;
      int h0 = holds;
      m.start();
      send(8'hb4, 1'b1);
      send(8'ha5, 1'b1);
      m.stop();
      chkn("flag pulses", 2, rises - r0);
      chkn("stretches", 0, holds - h0);
      pop(1'b1, 8'hb4);
      pop(1'b0, 8'ha5);
      $display("test plain done");
   endtask
   task automatic t_hold;
      @(posedge clk) hold <= 1'b1;
      m.start();
      fork
         send(8'hb4, 1'b1);
         begin
            wait_hi(held);
            repeat (30) @(posedge clk);
            #1 chk1("flag while held", 1'b1, flag);
            chk1("clock wire held", 1'b0, scl_w);
            @(posedge clk) rel <= 1'b1;
            @(posedge clk) rel <= 1'b0;
         end
      join
      m.stop();
      chk1("flag after release", 1'b0, flag);
      pop(1'b1, 8'hb4);
      @(posedge clk) hold <= 1'b0;
      $display("test hold done");
   endtask
   task automatic t_ten;
      int r0;
      @(posedge clk) ten <= 1'b1;
      own <= 10'h2c3;
      r0 = rises;
      m.start();
      send(8'hf4, 1'b1);
      send(8'hc3, 1'b1);
      send(8'h3c, 1'b1);
      m.stop();
      chkn("flag pulses", 3, rises - r0);
      pop(1'b1, 8'hf4);
      pop(1'b1, 8'hc3);
      pop(1'b0, 8'h3c);
      @(posedge clk) ten <= 1'b0;
      own <= 10'h05a;
      $display("test ten-bit done");
   endtask
   // foreign address with hold set, then a data byte equal to our own address
   task automatic t_miss;
      int r0 = rises;
      int h0 = holds;
      @(posedge clk) hold <= 1'b1;
      m.start();
      send(8'h22, 1'b0);
      send(8'hb4, 1'b0);
      m.stop();
      #1 chk1("buffer full", 1'b0, full);
      chkn("flag pulses", 0, rises - r0);
      chkn("stretches", 0, holds - h0);
      @(posedge clk) hold <= 1'b0;
      $display("test mismatch done");
   endtask
   // one byte more than the buffer holds; software stalls until the stretch
   task automatic t_fill;
      m.start();
      fork
         begin
            send(8'hb4, 1'b1);
            for (int i = 0; i < FIFO_DEPTH; i++) send(8'(i), 1'b1);
         end
         begin
            wait_hi(held);
            chk1("buffer full while stalled", 1'b1, full);
            pop(1'b1, 8'hb4);
            for (int i = 0; i < FIFO_DEPTH; i++) pop(1'b0, 8'(i));
         end
      join
      m.stop();
      chk1("buffer drained", 1'b0, full);
      $display("test fill done");
   endtask

   task automatic conclude;
      $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // reset spans enough link edges for its synchroniser
   initial begin
      repeat (5) @(posedge lclk);
      @(posedge clk) rst <= 1'b0;
      repeat (8) @(posedge lclk);
      @(posedge clk) #1;
      chk1("buffer full after reset", 1'b0, full);
      t_plain();
      t_hold();
      t_ten();
      t_miss();
      t_fill();
      conclude();
   end
endmodule
